//--- brt_rtc_core.sv
/*
 * BCD real-time clock core: time of day, calendar, alarms, sticky status
 * and an AHB-Lite register slave. Assumes one clock, a single AHB master
 * and software that follows the hold/grant sequence before setting time.
 */
// Behaviour
// - format bit 0 is 24-hour, 1 is 12-hour.
// - BCD units low nibble, tens above.
// - seconds accept and count 00 to 59.
// - minutes accept and count 00 to 59.
// - hours 1-12 or 0-23 by format.
// - time bit 22 is meridiem, 1 afternoon.
// - century accepts only 19 and 20.
// - year accepts and counts 00 to 99.
// - month accepts and counts 01 to 12.
// - weekday 1-7, never steers date counting.
// - date accepts and counts 01 to the month's last day.
// - seconds compared only when bit 7 set.
// - minutes compared only when bit 15 set.
// - hours and meridiem compared when bit 23.
// - month compared only when bit 23 set.
// - date compared only when bit 31 set.
// - grant flag reads one only while writable.
// - alarm flag sets on full match, sticky.
// - second flag sets each tick, sticky.
// - time and calendar event flags latch selected events.
// - alarm uses enabled fields only; seconds-only per minute.
// - illegal writes dropped, non-valid flag raised.
// - writing one clears a status flag.
`timescale 1ns/1ns
`include "brt_defs.svh"

module brt_rtc_core #(
	parameter int unsigned SEC_CYCLES = `BRT_SEC_CYCLES
) (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic RST_N,
	// AHB-Lite slave
	input wire logic HSEL,
	input wire brt_pkg::brt_word_t HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire brt_pkg::brt_word_t HWDATA,
	input wire logic HREADY,
	output brt_pkg::brt_word_t HRDATA,
	output logic HREADYOUT,
	output logic HRESP
);
	import brt_pkg::*;

	// ------------------------------------------------------------------
	// BCD helpers
	// ------------------------------------------------------------------
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		if (v[3:0] == 4'h9)
			return {v[7:4] + 4'h1, 4'h0};
		return v + 8'h01;
	endfunction

	function automatic logic bcd_ok(input logic [7:0] v);
		return (v[7:4] <= 4'h9) && (v[3:0] <= 4'h9);
	endfunction

	// Every year divisible by four leaps, except the 1900 wrap year.
	function automatic logic [5:0] last_day(input brt_cal_t c);
		logic leap;
		leap = (!c.year[4] && (c.year[3:0] == 4'h0 || c.year[3:0] == 4'h4
			|| c.year[3:0] == 4'h8)) || (c.year[4] && (c.year[3:0] == 4'h2
			|| c.year[3:0] == 4'h6));
		if (c.century_field == 7'h19 && c.year == 8'h00)
			leap = 1'b0;
		case (c.month)
			5'h02: return leap ? 6'h29 : 6'h28;
			5'h04, 5'h06, 5'h09, 5'h11: return 6'h30;
			default: return 6'h31;
		endcase
	endfunction

	function automatic logic ms_ok(input logic [6:0] v);
		return bcd_ok({1'b0, v}) && v <= 7'h59;
	endfunction

	function automatic logic hour_ok(input logic [5:0] h, input logic m,
		input logic f12);
		if (!bcd_ok({2'b00, h}))
			return 1'b0;
		return f12 ? (h >= 6'h01 && h <= 6'h12) : (h <= 6'h23 && !m);
	endfunction

	function automatic logic cal_ok(input brt_cal_t c);
		return (c.century_field == 7'h19 || c.century_field == 7'h20)
			&& bcd_ok(c.year)
			&& bcd_ok({3'b000, c.month}) && c.month >= 5'h01
			&& c.month <= 5'h12
			&& c.wday >= 3'd1 && c.wday <= 3'd7
			&& bcd_ok({2'b00, c.date}) && c.date >= 6'h01
			&& c.date <= last_day(c);
	endfunction

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	brt_mode_t mode;
	logic fmt12;
	brt_time_t tod;
	brt_cal_t cal;
	brt_talm_t talm;
	brt_calm_t calm;
	logic [4:0] sr;
	logic [3:0] nv;
	brt_upd_t upd, next_upd;
	logic [24:0] presc;
	logic tick, time_run, upd_d;
	logic wr_pend, hold_next;
	logic [7:0] wr_addr;
	brt_time_t next_tod;
	brt_cal_t next_cal;
	logic min_roll, hr_roll, noon, midnight, day_roll;
	logic week_chg, month_chg, year_chg;
	logic time_ev, cal_ev, alarm_hit;
	logic wr_time, wr_cal, wr_talm, wr_calm, wr_sclr;
	logic time_good, cal_good, talm_good, calm_good;
	brt_time_t w_time;
	brt_cal_t w_cal;
	brt_talm_t w_talm;
	brt_calm_t w_calm;
	brt_word_t rd_mux;

	// ------------------------------------------------------------------
	// AHB-Lite slave: zero wait states, reads sampled at the address phase
	// ------------------------------------------------------------------
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;

	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end
		else if (HREADY)
		begin
			wr_pend <= HSEL && HTRANS[1] && HWRITE;
			wr_addr <= HADDR[7:0];
		end
	end

	always_comb
	begin
		unique case (HADDR[7:0])
			`BRT_OFF_MODE: rd_mux = mode;
			`BRT_OFF_HFMT: rd_mux = {31'h0, fmt12};
			`BRT_OFF_TIME: rd_mux = tod;
			`BRT_OFF_CAL: rd_mux = cal;
			`BRT_OFF_TALM: rd_mux = talm;
			`BRT_OFF_CALM: rd_mux = calm;
			`BRT_OFF_STAT: rd_mux = {27'h0, sr};
			`BRT_OFF_VALID: rd_mux = {28'h0, nv};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
			HRDATA <= 32'h0000_0000;
		else if (HREADY && HSEL && HTRANS[1] && !HWRITE)
			HRDATA <= rd_mux;
	end

	assign w_time = brt_time_t'(HWDATA & `BRT_MASK_TIME);
	assign w_cal = brt_cal_t'(HWDATA & `BRT_MASK_CAL);
	assign w_talm = brt_talm_t'(HWDATA & `BRT_MASK_TALM);
	assign w_calm = brt_calm_t'(HWDATA & `BRT_MASK_CALM);

	// Counter writes pass only while the matching hold is granted.
	assign wr_time = wr_pend && wr_addr == `BRT_OFF_TIME && upd == UPD_OPEN
		&& mode.time_hold_request;
	assign wr_cal = wr_pend && wr_addr == `BRT_OFF_CAL && upd == UPD_OPEN
		&& mode.calendar_hold_request;
	assign wr_talm = wr_pend && wr_addr == `BRT_OFF_TALM;
	assign wr_calm = wr_pend && wr_addr == `BRT_OFF_CALM;
	assign wr_sclr = wr_pend && wr_addr == `BRT_OFF_SCLR;

	assign time_good = ms_ok(w_time.sec) && ms_ok(w_time.min)
		&& hour_ok(w_time.hour, w_time.meridiem_flag, fmt12);
	assign cal_good = cal_ok(w_cal);
	assign talm_good = (!w_talm.seconds_match_enable || ms_ok(w_talm.sec))
		&& (!w_talm.minutes_match_enable || ms_ok(w_talm.min))
		&& (!w_talm.hours_match_enable
		|| hour_ok(w_talm.hour, w_talm.meridiem_flag, fmt12));
	assign calm_good = (!w_calm.month_match_enable
		|| (bcd_ok({3'b000, w_calm.month}) && w_calm.month >= 5'h01
		&& w_calm.month <= 5'h12))
		&& (!w_calm.day_of_month_match_enable
		|| (bcd_ok({2'b00, w_calm.date}) && w_calm.date >= 6'h01
		&& w_calm.date <= 6'h31));

	// ------------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------------
	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			mode <= brt_mode_t'(32'h0000_0000);
			fmt12 <= 1'b0;
		end
		else if (wr_pend && wr_addr == `BRT_OFF_MODE)
			mode <= brt_mode_t'(HWDATA & `BRT_MASK_MODE);
		else if (wr_pend && wr_addr == `BRT_OFF_HFMT)
			fmt12 <= HWDATA[0];
	end

	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			talm <= brt_talm_t'(32'h0000_0000);
			calm <= brt_calm_t'(32'h0000_0000);
		end
		else
		begin
			if (wr_talm && talm_good)
				talm <= w_talm;
			if (wr_calm && calm_good)
				calm <= w_calm;
		end
	end

	// A non-valid flag drops only once an acceptable value is written.
	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
			nv <= 4'h0;
		else
		begin
			if (wr_time)
				nv[`BRT_NV_TIME] <= !time_good;
			if (wr_cal)
				nv[`BRT_NV_CAL] <= !cal_good;
			if (wr_talm)
				nv[`BRT_NV_TALM] <= !talm_good;
			if (wr_calm)
				nv[`BRT_NV_CALM] <= !calm_good;
		end
	end

	// ------------------------------------------------------------------
	// One-second time base and update grant
	// ------------------------------------------------------------------
	assign tick = presc == 25'(SEC_CYCLES - 1);
	assign time_run = tick && !mode.time_hold_request;

	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
			presc <= 25'h0;
		else if (tick)
			presc <= 25'h0;
		else
			presc <= presc + 25'h1;
	end

	// Holds as they stand after this edge, so a release drops the grant
	// at once instead of one cycle after the counters are free again.
	assign hold_next = (wr_pend && wr_addr == `BRT_OFF_MODE)
		? (HWDATA[0] || HWDATA[1])
		: (mode.time_hold_request || mode.calendar_hold_request);

	// The extra cycle in UPD_SYNC lets a counter step already under way
	// finish before software is told it may write.
	always_comb
	begin
		next_upd = upd;
		unique case (upd)
			UPD_RUN: if (mode.time_hold_request || mode.calendar_hold_request)
				next_upd = UPD_SYNC;
			UPD_SYNC: next_upd = UPD_OPEN;
			UPD_OPEN: if (!mode.time_hold_request
				&& !mode.calendar_hold_request)
				next_upd = UPD_RUN;
			default: next_upd = UPD_RUN;
		endcase
	end

	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
			upd <= UPD_RUN;
		else
			upd <= next_upd;
	end

	// ------------------------------------------------------------------
	// Time of day
	// ------------------------------------------------------------------
	always_comb
	begin
		next_tod = tod;
		min_roll = 1'b0;
		hr_roll = 1'b0;
		noon = 1'b0;
		midnight = 1'b0;
		if (time_run)
		begin
			if (tod.sec != 7'h59)
				next_tod.sec = 7'(bcd_inc({1'b0, tod.sec}));
			else
			begin
				next_tod.sec = 7'h00;
				min_roll = 1'b1;
				if (tod.min != 7'h59)
					next_tod.min = 7'(bcd_inc({1'b0, tod.min}));
				else
				begin
					next_tod.min = 7'h00;
					hr_roll = 1'b1;
					if (fmt12 && tod.hour == 6'h11)
					begin
						next_tod.hour = 6'h12;
						next_tod.meridiem_flag = !tod.meridiem_flag;
						noon = !tod.meridiem_flag;
						midnight = tod.meridiem_flag;
					end
					else if (fmt12 && tod.hour == 6'h12)
						next_tod.hour = 6'h01;
					else if (!fmt12 && tod.hour == 6'h23)
					begin
						next_tod.hour = 6'h00;
						midnight = 1'b1;
					end
					else
					begin
						next_tod.hour = 6'(bcd_inc({2'b00, tod.hour}));
						noon = !fmt12 && tod.hour == 6'h11;
					end
				end
			end
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
			tod <= brt_time_t'(32'h0000_0000);
		else if (wr_time)
		begin
			if (time_good)
				tod <= w_time;
		end
		else
			tod <= next_tod;
	end

	// ------------------------------------------------------------------
	// Calendar
	// ------------------------------------------------------------------
	assign day_roll = midnight && !mode.calendar_hold_request;

	always_comb
	begin
		next_cal = cal;
		week_chg = 1'b0;
		month_chg = 1'b0;
		year_chg = 1'b0;
		if (day_roll)
		begin
			next_cal.wday = (cal.wday == 3'd7) ? 3'd1 : cal.wday + 3'd1;
			week_chg = cal.wday == 3'd7;
			if (cal.date != last_day(cal))
				next_cal.date = 6'(bcd_inc({2'b00, cal.date}));
			else
			begin
				next_cal.date = 6'h01;
				month_chg = 1'b1;
				if (cal.month != 5'h12)
					next_cal.month = 5'(bcd_inc({3'b000, cal.month}));
				else
				begin
					next_cal.month = 5'h01;
					year_chg = 1'b1;
					next_cal.year = bcd_inc(cal.year);
					if (cal.year == 8'h99)
					begin
						next_cal.year = 8'h00;
						next_cal.century_field =
							(cal.century_field == 7'h19) ? 7'h20 : 7'h19;
					end
				end
			end
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
			cal <= brt_cal_t'(`BRT_RST_CAL);
		else if (wr_cal)
		begin
			if (cal_good)
				cal <= w_cal;
		end
		else
			cal <= next_cal;
	end

	// ------------------------------------------------------------------
	// Alarm compare and event selection
	// ------------------------------------------------------------------
	// Compare one cycle after a counter step so each second matches once.
	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
			upd_d <= 1'b0;
		else
			upd_d <= time_run;
	end

	assign alarm_hit = upd_d && (talm.seconds_match_enable
		|| talm.minutes_match_enable || talm.hours_match_enable
		|| calm.month_match_enable || calm.day_of_month_match_enable)
		&& (!talm.seconds_match_enable || talm.sec == tod.sec)
		&& (!talm.minutes_match_enable || talm.min == tod.min)
		&& (!talm.hours_match_enable || (talm.hour == tod.hour
		&& talm.meridiem_flag == tod.meridiem_flag))
		&& (!calm.month_match_enable || calm.month == cal.month)
		&& (!calm.day_of_month_match_enable || calm.date == cal.date);

	always_comb
	begin
		unique case (mode.time_sel)
			2'b00: time_ev = min_roll;
			2'b01: time_ev = hr_roll;
			2'b10: time_ev = midnight;
			2'b11: time_ev = noon;
		endcase
		unique case (mode.cal_sel)
			2'b00: cal_ev = week_chg;
			2'b01: cal_ev = month_chg;
			2'b10: cal_ev = year_chg;
			default: cal_ev = 1'b0;
		endcase
	end

	// ------------------------------------------------------------------
	// Sticky status: a set in the clearing cycle wins
	// ------------------------------------------------------------------
	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
			sr <= 5'h00;
		else
		begin
			sr[`BRT_SR_GRANT] <= hold_next && ((upd == UPD_SYNC)
				|| (upd == UPD_OPEN && sr[`BRT_SR_GRANT]
				&& !(wr_sclr && HWDATA[`BRT_SR_GRANT])));
			sr[`BRT_SR_ALARM] <= alarm_hit || (sr[`BRT_SR_ALARM]
				&& !(wr_sclr && HWDATA[`BRT_SR_ALARM]));
			sr[`BRT_SR_SEC] <= tick || (sr[`BRT_SR_SEC]
				&& !(wr_sclr && HWDATA[`BRT_SR_SEC]));
			sr[`BRT_SR_TIME_EV] <= time_ev || (sr[`BRT_SR_TIME_EV]
				&& !(wr_sclr && HWDATA[`BRT_SR_TIME_EV]));
			sr[`BRT_SR_CAL_EV] <= cal_ev || (sr[`BRT_SR_CAL_EV]
				&& !(wr_sclr && HWDATA[`BRT_SR_CAL_EV]));
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	chk_sec_wrap: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		time_run && !wr_time && tod.sec == 7'h59 |=> tod.sec == 7'h00)
		else $error("seconds did not wrap to zero");
	chk_min_step: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		time_run && tod.sec == 7'h59 && tod.min == 7'h09
		|=> tod.min == 7'h10 && $stable(tod.hour))
		else $error("minute units did not carry into tens");
	chk_hour_wrap: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		time_run && !fmt12 && tod.hour == 6'h23 && tod.min == 7'h59
		&& tod.sec == 7'h59 |=> tod.hour == 6'h00 && tod.min == 7'h00)
		else $error("24-hour clock did not wrap at midnight");
	chk_noon_flip: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		time_run && fmt12 && tod.hour == 6'h11 && tod.min == 7'h59
		&& tod.sec == 7'h59 |=> tod.hour == 6'h12
		&& tod.meridiem_flag != $past(tod.meridiem_flag))
		else $error("meridiem did not change at twelve");
	chk_cal_reject: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		wr_cal && !cal_good |=> nv[`BRT_NV_CAL] && $stable(cal))
		else $error("illegal calendar value was loaded");
	chk_alarm_set: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		alarm_hit |=> sr[`BRT_SR_ALARM] ##1 (sr[`BRT_SR_ALARM]
		|| $past(wr_sclr)))
		else $error("alarm flag not set and held");
	chk_sec_only: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		upd_d && talm.seconds_match_enable && !talm.minutes_match_enable
		&& !talm.hours_match_enable && !calm.month_match_enable
		&& !calm.day_of_month_match_enable && tod.sec == talm.sec
		|-> alarm_hit)
		else $error("seconds-only alarm missed its match");
	chk_grant_only: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		sr[`BRT_SR_GRANT] |-> upd == UPD_OPEN
		&& (mode.time_hold_request || mode.calendar_hold_request))
		else $error("grant flag shown while counters run");
	chk_sec_clear: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		wr_sclr && HWDATA[`BRT_SR_SEC] && !tick |=> !sr[`BRT_SR_SEC])
		else $error("second flag survived a clear");
	chk_sec_tick: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		tick |=> sr[`BRT_SR_SEC] ##1 (sr[`BRT_SR_SEC] || $past(wr_sclr)))
		else $error("second flag not set by tick");
	chk_wday_wrap: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		day_roll && !wr_cal && cal.wday == 3'd7 |=> cal.wday == 3'd1)
		else $error("weekday did not wrap to one");

endmodule

//--- brt_defs.svh
/*
 * Offsets, field positions, reset values and timing counts for the BCD
 * real-time clock core. Assumes byte addresses on a 32-bit register bus.
 */
`ifndef BRT_DEFS_SVH
`define BRT_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define BRT_OFF_MODE 8'h00
`define BRT_OFF_HFMT 8'h04
`define BRT_OFF_TIME 8'h08
`define BRT_OFF_CAL 8'h0C
`define BRT_OFF_TALM 8'h10
`define BRT_OFF_CALM 8'h14
`define BRT_OFF_STAT 8'h18
`define BRT_OFF_SCLR 8'h1C
`define BRT_OFF_VALID 8'h2C

// ----------------------------------------------------------------------
// Status and valid-entry bit positions
// ----------------------------------------------------------------------
`define BRT_SR_GRANT 0
`define BRT_SR_ALARM 1
`define BRT_SR_SEC 2
`define BRT_SR_TIME_EV 3
`define BRT_SR_CAL_EV 4
`define BRT_NV_TIME 0
`define BRT_NV_CAL 1
`define BRT_NV_TALM 2
`define BRT_NV_CALM 3

// ----------------------------------------------------------------------
// Reset values and writable-bit masks
// ----------------------------------------------------------------------
`define BRT_RST_CAL 32'h01819819
`define BRT_MASK_MODE 32'h00030303
`define BRT_MASK_TIME 32'h007F7F7F
`define BRT_MASK_CAL 32'h3FFFFF7F
`define BRT_MASK_TALM 32'h00FFFFFF
`define BRT_MASK_CALM 32'hBF9F0000

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define BRT_CLK_NS 50
`define BRT_SEC_NS 1000000000
`define BRT_SEC_CYCLES (`BRT_SEC_NS / `BRT_CLK_NS)

`endif

//--- brt_pkg.sv
/*
 * Types of the BCD real-time clock core: register layouts and the
 * update-grant states. Assumes brt_defs.svh carries the numbers.
 */
package brt_pkg;

	typedef logic [31:0] brt_word_t;

	typedef struct packed {
		logic [13:0] rsv2;
		logic [1:0] cal_sel;
		logic [5:0] rsv1;
		logic [1:0] time_sel;
		logic [5:0] rsv0;
		logic calendar_hold_request;
		logic time_hold_request;
	} brt_mode_t;

	typedef struct packed {
		logic [8:0] rsv;
		logic meridiem_flag;
		logic [5:0] hour;
		logic pad1;
		logic [6:0] min;
		logic pad0;
		logic [6:0] sec;
	} brt_time_t;

	typedef struct packed {
		logic [1:0] rsv;
		logic [5:0] date;
		logic [2:0] wday;
		logic [4:0] month;
		logic [7:0] year;
		logic pad;
		logic [6:0] century_field;
	} brt_cal_t;

	typedef struct packed {
		logic [7:0] rsv;
		logic hours_match_enable;
		logic meridiem_flag;
		logic [5:0] hour;
		logic minutes_match_enable;
		logic [6:0] min;
		logic seconds_match_enable;
		logic [6:0] sec;
	} brt_talm_t;

	typedef struct packed {
		logic day_of_month_match_enable;
		logic pad1;
		logic [5:0] date;
		logic month_match_enable;
		logic [1:0] pad0;
		logic [4:0] month;
		logic [15:0] rsv;
	} brt_calm_t;

	typedef enum logic [1:0] {
		UPD_RUN = 2'b00,
		UPD_SYNC = 2'b01,
		UPD_OPEN = 2'b11
	} brt_upd_t;

endpackage

//--- bcd_rtc_time_calendar_alarm_bench.sv
/*
 * Self-checking bench for the BCD clock core: AHB-Lite register reads and
 * writes, checked against values worked out by hand.
 * Assumes a core built with a 20-cycle second so that rollovers come soon.
 */
`timescale 1ns/1ns

module bcd_rtc_time_calendar_alarm_bench;
	import brt_pkg::*;

	// ------------------------------------------------------------------
	// Signals and counters
	// ------------------------------------------------------------------
	localparam brt_word_t all_bits = 32'hFFFFFFFF;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b0;
	brt_word_t haddr = '0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	brt_word_t hwdata = '0;
	brt_word_t hrdata;
	logic hreadyout;
	logic hresp;
	brt_word_t rd;
	int bad_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	// Illegal writes: target offset and the value that must be refused.
	logic [7:0] il_a [9] = '{8'h08, 8'h08, 8'h08, 8'h0C, 8'h0C, 8'h0C,
		8'h0C, 8'h10, 8'h14};
	brt_word_t il_d [9] = '{32'h00235960, 32'h00236058, 32'h00245958,
		32'h31F29921, 32'h31F39920, 32'h32F29920, 32'h31F29A20,
		32'h000000E0, 32'h00930000};

	brt_rtc_core #(.SEC_CYCLES(20)) DUT (
		.CORE_CLK(clk),
		.RST_N(rst_n),
		.HSEL(hsel),
		.HADDR(haddr),
		.HTRANS(htrans),
		.HWRITE(hwrite),
		.HSIZE(3'h2),
		.HWDATA(hwdata),
		.HREADY(hreadyout),
		.HRDATA(hrdata),
		.HREADYOUT(hreadyout),
		.HRESP(hresp)
	);

	always #25 clk = ~clk;

	// ------------------------------------------------------------------
	// Bus tasks and checks
	// ------------------------------------------------------------------
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// A hang anywhere ends the run through the same verdict.
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			bad_count++;
			give_verdict();
		end
	end

	task automatic check(input brt_word_t got, input brt_word_t exp);
		samples_checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One single transfer; entered just after a rising edge.
	task automatic xfer(input logic is_wr, input logic [7:0] a,
		input brt_word_t wd);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		hwrite <= is_wr;
		htrans <= 2'b10;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic put(input logic [7:0] a, input brt_word_t d);
		xfer(1'b1, a, d);
	endtask

	task automatic rchk(input logic [7:0] a, input brt_word_t exp,
		input brt_word_t m);
		xfer(1'b0, a, '0);
		check(rd & m, exp);
	endtask

	// Reads until the masked value appears; the bound keeps it finite.
	task automatic poll(input logic [7:0] a, input brt_word_t exp,
		input brt_word_t m);
		int n;
		n = 0;
		do
		begin
			xfer(1'b0, a, '0);
			n++;
		end
		while ((rd & m) !== exp && n < 300);
		check(rd & m, exp);
	endtask

	task automatic end_test(input string s);
		$display("test %s done", s);
	endtask

	// ------------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------------
	initial
	begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rchk(8'h18, 32'h0, 32'h1B);
		rchk(8'h04, 32'h0, all_bits);
		rchk(8'h08, 32'h0, all_bits);
		rchk(8'h0C, 32'h01819819, all_bits);
		rchk(8'h10, 32'h0, all_bits);
		rchk(8'h14, 32'h0, all_bits);
		rchk(8'h30, 32'h0, all_bits);
		end_test("reset");
		// Hold both counters, midnight and year events selected.
		put(8'h00, 32'h00020203);
		poll(8'h18, 32'h1, 32'h1);
		put(8'h08, 32'h00235958);
		put(8'h0C, 32'h31F29920);
		rchk(8'h08, 32'h00235958, all_bits);
		rchk(8'h0C, 32'h31F29920, all_bits);
		for (int i = 0; i < 9; i++)
		begin
			brt_word_t g;
			brt_word_t b;
			g = (il_a[i] == 8'h08) ? 32'h00235958 :
				(il_a[i] == 8'h0C) ? 32'h31F29920 : 32'h0;
			b = 32'h1 << ((il_a[i] - 8'h08) >> 2);
			put(il_a[i], g);
			put(il_a[i], il_d[i]);
			rchk(il_a[i], g, all_bits);
			rchk(8'h2C, b, b);
			put(il_a[i], g);
			rchk(8'h2C, 32'h0, b);
		end
		end_test("entry");
		put(8'h00, 32'h00020200);
		put(8'h1C, 32'h0000001F);
		poll(8'h08, 32'h0, all_bits);
		rchk(8'h0C, 32'h01210019, all_bits);
		rchk(8'h18, 32'h1C, 32'h1F);
		end_test("rollover");
		// Seconds alarm only; the minute field differs but is disabled.
		put(8'h1C, 32'h0000001F);
		put(8'h10, 32'h00003085);
		poll(8'h08, 32'h04, 32'h7F);
		rchk(8'h18, 32'h0, 32'h2);
		poll(8'h08, 32'h06, 32'h7F);
		rchk(8'h18, 32'h2, 32'h2);
		put(8'h1C, 32'h0);
		rchk(8'h18, 32'h2, 32'h2);
		put(8'h1C, 32'h2);
		rchk(8'h18, 32'h0, 32'h2);
		end_test("alarm");
		put(8'h04, 32'h1);
		rchk(8'h04, 32'h1, all_bits);
		// Time hold with the noon event selected.
		put(8'h00, 32'h00000301);
		poll(8'h18, 32'h1, 32'h1);
		put(8'h08, 32'h00115958);
		put(8'h08, 32'h00135958);
		rchk(8'h08, 32'h00115958, all_bits);
		rchk(8'h2C, 32'h1, 32'h1);
		rchk(8'h18, 32'h0, 32'h8);
		put(8'h00, 32'h00000300);
		poll(8'h08, 32'h00520000, all_bits);
		rchk(8'h18, 32'h8, 32'h18);
		end_test("meridiem");
		give_verdict();
	end
endmodule
